//--- rtl/serial_adc_control.sv
// serial_adc_control: digital side of an eight-channel 8-bit serial converter.
// assumes clk oversamples the serial pins; conversion codes arrive on analogIn on clk.
// Contract
// - control word bits 7, 6, 2, 1, 0 have no effect.
// - channel field is control bits 5..3, bit 5 most significant.
// - channel received now selects the input of the next conversion.
// - field is a plain index 0..7; channel 0 after reset.
// - results are unsigned straight binary codes, 256 values.
// - powered while chip select low, powered down while it is high.
// - continuous mode naps from 16th falling edge to next 1st falling edge.
// - each conversion takes exactly 16 serial clock cycles.
// - conversions run back to back while chip select stays low.
// - control word captured on first 8 rising edges of each conversion.
// - out zeros on falls 1-4, result msb first 5-12, zeros 13-16.
// - data output driven only while chip select is low.
`timescale 1ns/1ns
module serial_adc_control #(
	parameter int NUM_CHANNELS = serial_adc_pkg::NUM_CHANNELS,
	parameter int BUF_DEPTH = serial_adc_pkg::BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclkPin,
	input wire logic csPinN,
	input wire logic dinPin,
	output logic doutPin,
	output logic doutOeN,
	input wire logic [NUM_CHANNELS-1:0][serial_adc_pkg::RESULT_BITS-1:0] analogIn,
	output logic powerUp,
	output logic trackMode,
	output logic [serial_adc_pkg::CHAN_W-1:0] sampleChannel,
	output logic [serial_adc_pkg::CTRL_BITS-1:0] channelSelectControl,
	output logic [serial_adc_pkg::RESULT_BITS-1:0] lastResult,
	output logic [serial_adc_pkg::CHAN_W-1:0] lastResultChannel
);

	// pin synchronisers: meta stage feeds only the sync stage
	logic [2:0] pinMeta_reg;
	logic [2:0] pinSync_reg;
	logic [2:0] pinPrev_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinMeta_reg <= serial_adc_pkg::PIN_IDLE;
			pinSync_reg <= serial_adc_pkg::PIN_IDLE;
			pinPrev_reg <= serial_adc_pkg::PIN_IDLE;
		end else begin
			pinMeta_reg <= {dinPin, csPinN, sclkPin};
			pinSync_reg <= pinMeta_reg;
			pinPrev_reg <= pinSync_reg;
		end
	end

	wire sclkNow = pinSync_reg[serial_adc_pkg::PIN_SCLK];
	wire sclkOld = pinPrev_reg[serial_adc_pkg::PIN_SCLK];
	wire csNowN = pinSync_reg[serial_adc_pkg::PIN_CS];
	wire csOldN = pinPrev_reg[serial_adc_pkg::PIN_CS];
	wire dinNow = pinSync_reg[serial_adc_pkg::PIN_DIN];

	// serial clock is gated off while chip select is high
	wire inFrame = ~csNowN;
	wire csFall = csOldN & ~csNowN;
	wire sclkRise = inFrame & ~csFall & ~sclkOld & sclkNow;
	wire sclkFall = inFrame & ~csFall & sclkOld & ~sclkNow;

	// edge counters
	logic [serial_adc_pkg::RISE_W-1:0] riseCnt_reg;
	logic [serial_adc_pkg::RISE_W-1:0] riseCnt_next;
	logic [serial_adc_pkg::FALL_W-1:0] fallCnt_reg;
	logic [serial_adc_pkg::FALL_W-1:0] fallCnt_next;

	// number the current falling edge will carry within its conversion
	wire [serial_adc_pkg::FALL_W-1:0] fallNum =
		(fallCnt_reg == serial_adc_pkg::FALL_LAST) ? serial_adc_pkg::FALL_FIRST : fallCnt_reg + 1'b1;

	// chip select falling with the clock low counts as the first falling edge
	wire csFallAsEdge = csFall & ~sclkNow;
	wire firstFall = csFallAsEdge | (sclkFall & (fallNum == serial_adc_pkg::FALL_FIRST));
	wire lastFall = sclkFall & (fallNum == serial_adc_pkg::FALL_LAST);
	wire sampleFall = sclkFall & (fallNum == serial_adc_pkg::FALL_SAMPLE);
	wire dataFall = sclkFall & (fallNum >= serial_adc_pkg::FALL_DATA_FIRST)
		& (fallNum <= serial_adc_pkg::FALL_DATA_LAST);
	wire dataDone = sclkFall & (fallNum == serial_adc_pkg::FALL_DATA_LAST);

	wire ctrlPhase = riseCnt_reg <= serial_adc_pkg::RISE_CTRL_LAST;
	wire ctrlCapture = sclkRise & ctrlPhase;
	wire ctrlCommit = sclkRise & (riseCnt_reg == serial_adc_pkg::RISE_CTRL_LAST);
	wire convEnd = sclkRise & (riseCnt_reg == serial_adc_pkg::RISE_LAST);

	always_comb begin
		riseCnt_next = riseCnt_reg;
		if (~inFrame | csFall) begin
			riseCnt_next = '0;
		end else if (sclkRise) begin
			riseCnt_next = (riseCnt_reg == serial_adc_pkg::RISE_LAST) ? '0 : riseCnt_reg + 1'b1;
		end
	end

	always_comb begin
		fallCnt_next = fallCnt_reg;
		if (~inFrame) begin
			fallCnt_next = '0;
		end else if (csFall) begin
			fallCnt_next = csFallAsEdge ? serial_adc_pkg::FALL_FIRST : '0;
		end else if (sclkFall) begin
			fallCnt_next = fallNum;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			riseCnt_reg <= '0;
			fallCnt_reg <= '0;
		end else begin
			riseCnt_reg <= riseCnt_next;
			fallCnt_reg <= fallCnt_next;
		end
	end

	// control word shift-in
	logic [serial_adc_pkg::CTRL_BITS-1:0] ctrlShift_reg;
	logic [serial_adc_pkg::CTRL_BITS-1:0] channelSelectControl_reg;
	logic [serial_adc_pkg::CHAN_W-1:0] convChan_reg;

	wire [serial_adc_pkg::CTRL_BITS-1:0] ctrlWord =
		{ctrlShift_reg[serial_adc_pkg::CTRL_BITS-2:0], dinNow};
	wire [serial_adc_pkg::CHAN_W-1:0] ctrlChan =
		channelSelectControl_reg[serial_adc_pkg::CHAN_MSB:serial_adc_pkg::CHAN_LSB];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrlShift_reg <= serial_adc_pkg::CTRL_RESET;
		end else if (ctrlCapture) begin
			ctrlShift_reg <= ctrlWord;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channelSelectControl_reg <= serial_adc_pkg::CTRL_RESET;
		end else if (ctrlCommit) begin
			channelSelectControl_reg <= ctrlWord;
		end
	end

	// the new field waits for the conversion boundary so the current sample is untouched
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			convChan_reg <= serial_adc_pkg::DEFAULT_CHANNEL;
		end else if (convEnd) begin
			convChan_reg <= ctrlChan;
		end
	end

	// power management
	serial_adc_pkg::power_e pwrState_reg;
	serial_adc_pkg::power_e pwrState_next;

	always_comb begin
		pwrState_next = pwrState_reg;
		case (pwrState_reg)
			serial_adc_pkg::PWR_OFF: begin
				if (inFrame) begin
					pwrState_next = serial_adc_pkg::PWR_ON;
				end
			end
			serial_adc_pkg::PWR_ON: begin
				if (~inFrame) begin
					pwrState_next = serial_adc_pkg::PWR_OFF;
				end else if (lastFall) begin
					pwrState_next = serial_adc_pkg::PWR_NAP;
				end
			end
			serial_adc_pkg::PWR_NAP: begin
				if (~inFrame) begin
					pwrState_next = serial_adc_pkg::PWR_OFF;
				end else if (firstFall) begin
					pwrState_next = serial_adc_pkg::PWR_ON;
				end
			end
			default: begin
				pwrState_next = serial_adc_pkg::PWR_OFF;
			end
		endcase
	end

	wire trackNext = inFrame & (fallCnt_next >= serial_adc_pkg::FALL_FIRST)
		& (fallCnt_next <= serial_adc_pkg::FALL_TRACK_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwrState_reg <= serial_adc_pkg::PWR_OFF;
			powerUp <= 1'b0;
			trackMode <= 1'b0;
			sampleChannel <= serial_adc_pkg::DEFAULT_CHANNEL;
		end else begin
			pwrState_reg <= pwrState_next;
			powerUp <= pwrState_next == serial_adc_pkg::PWR_ON;
			trackMode <= trackNext;
			sampleChannel <= convChan_reg;
		end
	end

	// sampling into the buffer at the end of track
	serial_adc_pkg::sample_s sampleIn;
	serial_adc_pkg::sample_s sampleOut;
	logic bufInReady;
	logic bufOutValid;
	logic shiftBusy_reg;

	assign sampleIn.chan = convChan_reg;
	assign sampleIn.code = analogIn[convChan_reg];

	// shifter only takes a word when idle, so a late pop never tears a result
	wire bufOutReady = ~shiftBusy_reg;
	wire bufPop = bufOutValid & bufOutReady;

	two_entry_buffer #(
		.WIDTH($bits(serial_adc_pkg::sample_s)),
		.DEPTH(BUF_DEPTH)
	) resultBuffer (
		.clk(clk),
		.rst(rst),
		.inValid(sampleFall),
		.inReady(bufInReady),
		.inData(sampleIn),
		.outValid(bufOutValid),
		.outReady(bufOutReady),
		.outData(sampleOut)
	);

	// output shifter
	logic [serial_adc_pkg::RESULT_BITS-1:0] resShift_reg;
	logic doutNext;

	always_comb begin
		doutNext = doutPin;
		if (~inFrame | csFall) begin
			doutNext = 1'b0;
		end else if (sclkFall) begin
			doutNext = dataFall & shiftBusy_reg & resShift_reg[serial_adc_pkg::RESULT_BITS-1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resShift_reg <= '0;
			shiftBusy_reg <= 1'b0;
		end else if (bufPop) begin
			resShift_reg <= sampleOut.code;
			shiftBusy_reg <= 1'b1;
		end else if (~inFrame) begin
			// an aborted frame drops the word being shifted
			shiftBusy_reg <= 1'b0;
		end else if (dataFall) begin
			resShift_reg <= {resShift_reg[serial_adc_pkg::RESULT_BITS-2:0], 1'b0};
			shiftBusy_reg <= ~dataDone;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lastResult <= '0;
			lastResultChannel <= serial_adc_pkg::DEFAULT_CHANNEL;
		end else if (bufPop) begin
			lastResult <= sampleOut.code;
			lastResultChannel <= sampleOut.chan;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			doutPin <= 1'b0;
			doutOeN <= 1'b1;
			channelSelectControl <= serial_adc_pkg::CTRL_RESET;
		end else begin
			doutPin <= doutNext;
			doutOeN <= csNowN;
			channelSelectControl <= channelSelectControl_reg;
		end
	end

endmodule

//--- rtl/serial_adc_pkg.sv
// serial_adc_pkg: constants and carriers shared by the serial converter control logic.
// assumes a single system clock that oversamples the serial pins by a wide margin.
package serial_adc_pkg;

	// serial frame geometry
	localparam int FRAME_EDGES = 16;
	localparam int CTRL_BITS = 8;
	localparam int RESULT_BITS = 8;
	localparam int NUM_CHANNELS = 8;
	localparam int CHAN_W = 3;
	localparam int RISE_W = 4;
	localparam int FALL_W = 5;

	// control word field positions
	localparam int CHAN_MSB = 5;
	localparam int CHAN_LSB = 3;

	// falling-edge numbers inside one conversion
	localparam logic [FALL_W-1:0] FALL_FIRST = 5'h01;
	localparam logic [FALL_W-1:0] FALL_TRACK_LAST = 5'h03;
	localparam logic [FALL_W-1:0] FALL_SAMPLE = 5'h04;
	localparam logic [FALL_W-1:0] FALL_DATA_FIRST = 5'h05;
	localparam logic [FALL_W-1:0] FALL_DATA_LAST = 5'h0C;
	localparam logic [FALL_W-1:0] FALL_LAST = 5'h10;

	// rising-edge indices (zero based) inside one conversion
	localparam logic [RISE_W-1:0] RISE_CTRL_LAST = 4'h7;
	localparam logic [RISE_W-1:0] RISE_LAST = 4'hF;

	// reset values
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 8'h00;
	localparam logic [CHAN_W-1:0] DEFAULT_CHANNEL = 3'h0;

	// pin sampling vector: bit positions and idle level (chip select high)
	localparam int PIN_SCLK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_DIN = 2;
	localparam logic [2:0] PIN_IDLE = 3'h3;

	// buffer between the sampler and the output shifter
	localparam int BUF_DEPTH = 2;

	typedef enum {
		PWR_OFF,
		PWR_ON,
		PWR_NAP
	} power_e;

	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [RESULT_BITS-1:0] code;
	} sample_s;

endpackage

//--- rtl/two_entry_buffer.sv
// two_entry_buffer: small valid/ready fifo holding sampled results.
// assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] COUNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;

	wire push = inValid & inReady;
	wire pop = outValid & outReady;

	assign inReady = count_reg != COUNT_FULL;
	assign outValid = count_reg != '0;
	assign outData = mem[rdPtr_reg];

	always_comb begin
		count_next = count_reg;
		if (push & ~pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop & ~push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
			end
		end
	end

	// storage needs no reset: count guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

endmodule

//--- test/serial_adc_control_checker.sv
// serial_adc_control_checker: port-level assertions for the serial converter control.
// assumes clk oversamples the pins and analogIn stays still while chip select is low.
`timescale 1ns/1ns
module serial_adc_control_checker #(
	parameter int NUM_CHANNELS = 8,
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclkPin,
	input wire logic csPinN,
	input wire logic dinPin,
	input wire logic doutPin,
	input wire logic doutOeN,
	input wire logic [NUM_CHANNELS-1:0][serial_adc_pkg::RESULT_BITS-1:0] analogIn,
	input wire logic powerUp,
	input wire logic trackMode,
	input wire logic [serial_adc_pkg::CHAN_W-1:0] sampleChannel,
	input wire logic [serial_adc_pkg::CTRL_BITS-1:0] channelSelectControl,
	input wire logic [serial_adc_pkg::RESULT_BITS-1:0] lastResult,
	input wire logic [serial_adc_pkg::CHAN_W-1:0] lastResultChannel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// a nap lasts a whole serial clock period, far more than eight clocks
	sequence napHeld;
		!powerUp [*8];
	endsequence
	sequence trackHeld;
		trackMode [*8];
	endsequence
	sequence resultLoaded;
		##[1:6] (lastResult == analogIn[lastResultChannel] && lastResultChannel == sampleChannel);
	endsequence
	AST_OE_OFF: assert property ($rose(csPinN) |-> ##[1:6] doutOeN)
		else $error("output enable kept after chip select rose");
	AST_OE_ON: assert property ($fell(csPinN) |-> ##[1:6] !doutOeN)
		else $error("output not enabled after chip select fell");
	AST_DOUT_IDLE: assert property (doutOeN |-> !doutPin)
		else $error("data out not zero while disabled");
	AST_POWER_OFF: assert property ($rose(csPinN) |-> ##[1:6] !powerUp)
		else $error("still powered after chip select rose");
	AST_POWER_ON: assert property ($fell(csPinN) |-> ##[1:6] powerUp)
		else $error("not powered after chip select fell");
	AST_TRACK_QUIET: assert property (trackMode |-> !doutPin)
		else $error("data out not zero during track");
	AST_CHAN_FROM_WORD: assert property ($changed(sampleChannel) |-> sampleChannel == $past(channelSelectControl[5:3]))
		else $error("sample channel not taken from word bits 5 to 3");
	AST_RESULT_LOAD: assert property ($fell(trackMode) |-> resultLoaded)
		else $error("result not the code of the sampled channel");
	AST_NAP_HOLDS: assert property ($fell(powerUp) |-> !trackMode ##1 napHeld)
		else $error("power-down too short");
	AST_TRACK_SPAN: assert property ($rose(trackMode) |-> trackHeld)
		else $error("track phase too short");
endmodule
bind serial_adc_control serial_adc_control_checker #(.NUM_CHANNELS(NUM_CHANNELS), .BUF_DEPTH(BUF_DEPTH))
	serial_adc_control_checker_i (.clk(clk), .rst(rst), .sclkPin(sclkPin), .csPinN(csPinN), .dinPin(dinPin),
	.doutPin(doutPin), .doutOeN(doutOeN), .analogIn(analogIn), .powerUp(powerUp), .trackMode(trackMode),
	.sampleChannel(sampleChannel), .channelSelectControl(channelSelectControl), .lastResult(lastResult),
	.lastResultChannel(lastResultChannel));

//--- test/serial_adc_control_tb_top.sv
// serial_adc_control_tb_top: scenario tests of the serial converter control.
// assumes the host model owns the serial pins; the bench owns reset and codes.
`timescale 1ns/1ns
module serial_adc_control_tb_top;
	logic clk, rst, sclkPin, csPinN, dinPin, doutPin, doutOeN, powerUp, trackMode;
	logic [serial_adc_pkg::NUM_CHANNELS-1:0][serial_adc_pkg::RESULT_BITS-1:0] analogIn;
	logic [2:0] sampleChannel, lastResultChannel, prev;
	logic [7:0] channelSelectControl, lastResult;
	logic [15:0] seen;
	int failures, comparisons;
	// with no pull on the line, a released output shows the inverse, so a late enable spoils the padding
	wire doutLine = doutOeN ? ~doutPin : doutPin;
	serial_adc_control serial_adc_control_i (.clk(clk), .rst(rst), .sclkPin(sclkPin), .csPinN(csPinN),
		.dinPin(dinPin), .doutPin(doutPin), .doutOeN(doutOeN), .analogIn(analogIn), .powerUp(powerUp),
		.trackMode(trackMode), .sampleChannel(sampleChannel), .channelSelectControl(channelSelectControl),
		.lastResult(lastResult), .lastResultChannel(lastResultChannel));
	serial_host_model serial_host_model_i (.sclkPin(sclkPin), .csPinN(csPinN), .dinPin(dinPin),
		.doutPin(doutLine));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task checkBit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic conv(input logic [7:0] word, input logic [2:0] expChan);
		serial_host_model_i.convert(word, seen);
		checkByte("result", analogIn[expChan], seen[11:4]);
		checkByte("padding", 8'h00, {seen[15:12], seen[3:0]});
		checkByte("control", word, channelSelectControl);
		checkByte("channel", {5'h00, word[5:3]}, {5'h00, sampleChannel});
		checkByte("lastResult", analogIn[expChan], lastResult);
		checkByte("lastResultChannel", {5'h00, expChan}, {5'h00, lastResultChannel});
		checkBit("nap", 1'b0, powerUp);
		prev = word[5:3];
	endtask
	task automatic idleCheck();
		checkBit("powerUp", 1'b0, powerUp);
		checkBit("doutOeN", 1'b1, doutOeN);
		checkBit("doutPin", 1'b0, doutPin);
	endtask
	task automatic testDefault();
		serial_host_model_i.open();
		checkBit("powered", 1'b1, powerUp);
		checkBit("enabled", 1'b0, doutOeN);
		conv(8'hEF, 3'h0);
		serial_host_model_i.close();
		idleCheck();
		$display("test default done");
	endtask
	task automatic testContinuous();
		serial_host_model_i.open();
		for (int k = 0; k < 9; k++) begin
			conv({2'(k), 3'(7 - k), 3'(~k)}, prev);
		end
		serial_host_model_i.close();
		idleCheck();
		$display("test continuous done");
	endtask
	// codes change only while deselected, so each frame shows the fresh code
	task automatic testBurst();
		for (int f = 0; f < 3; f++) begin
			@(posedge clk);
			#1 analogIn[prev] = (f == 1) ? 8'hFF : 8'h00;
			serial_host_model_i.open();
			conv({2'h3, 3'(f + 2), 3'h7}, prev);
			serial_host_model_i.close();
			idleCheck();
		end
		$display("test burst done");
	endtask
	task automatic testReset();
		@(posedge clk);
		#1 rst = 1'b1;
		analogIn[3] = 8'h5A;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		checkByte("reset control", 8'h00, channelSelectControl);
		checkByte("reset channel", 8'h00, {5'h00, sampleChannel});
		serial_host_model_i.open();
		conv(8'h18, 3'h0);
		conv(8'h00, 3'h3);
		serial_host_model_i.close();
		$display("test reset done");
	endtask
	initial begin
		rst = 1'b1;
		prev = 3'h0;
		for (int i = 0; i < 8; i++) begin
			analogIn[i] = 8'hA5 ^ 8'(i * 31);
		end
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		testDefault();
		testContinuous();
		testBurst();
		testReset();
		results();
	end
	// 15 conversions of 2 us each; five times that is ample
	initial begin
		#150000;
		failures++;
		results();
	end
endmodule

//--- test/serial_host_model.sv
// serial_host_model: behavioural host framing conversions on the serial pins.
// assumes the bench calls one task at a time; sclk idles high between frames.
`timescale 1ns/1ns
module serial_host_model (
	output logic sclkPin,
	output logic csPinN,
	output logic dinPin,
	input wire logic doutPin
);
	initial begin
		sclkPin = 1'b1;
		csPinN = 1'b1;
		dinPin = 1'b0;
	end
	task automatic open();
		csPinN = 1'b0;
		#63;
	endtask
	task automatic convert(input logic [7:0] word, output logic [15:0] seen);
		for (int i = 0; i < 16; i++) begin
			sclkPin = 1'b0;
			dinPin = (i < 8) ? word[7 - i] : ~dinPin;
			#62;
			seen[15 - i] = doutPin;
			sclkPin = 1'b1;
			#63;
		end
	endtask
	// whole conversions only; din flipped so a stale bit never passes
	task automatic close();
		csPinN = 1'b1;
		dinPin = ~dinPin;
		#250;
	endtask
endmodule
